/* File: flash_selfprog_pkg.sv */
// Package with constants shared by both ends of the flash self-programming link.
package flash_selfprog_pkg;

  // ==========================================================================
  // Control register layout and command codes
  // ==========================================================================
  localparam int unsigned CTRL_W         = 8;
  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned BIT_ERASE      = 1;
  localparam int unsigned BIT_WRITE      = 2;
  localparam int unsigned BIT_CLEAR      = 4;
  localparam logic [5:0]  CMD_LOAD       = 6'h01;
  localparam logic [5:0]  CMD_ERASE      = 6'h03;
  localparam logic [5:0]  CMD_WRITE      = 6'h05;
  localparam logic [5:0]  CMD_CLEAR      = 6'h11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // Geometry and timing
  // ==========================================================================
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned WORD_W         = 6;
  localparam int unsigned ARM_CYCLES     = 4;
  localparam int unsigned ERASE_TIME_NS  = 4000;
  localparam int unsigned WRITE_TIME_NS  = 4000;
  localparam int unsigned CLOCK_NS       = 5;
  localparam int unsigned ERASE_CYCLES   = ERASE_TIME_NS / CLOCK_NS;
  localparam int unsigned WRITE_CYCLES   = WRITE_TIME_NS / CLOCK_NS;
  localparam int unsigned TIMER_W        = 16;

endpackage : flash_selfprog_pkg

/* File: flash_selfprog_if.sv */
// Interface joining the processor-side master and the flash sequencer.
`timescale 1ns/1ps
interface flash_selfprog_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        store_prog_instr;
  logic [15:0] addr_pointer;
  logic [15:0] data_register_pair;
  logic        eeprom_busy;
  logic        core_stall;
  logic        busy;

  modport device (
    input  ctrl_wr, ctrl_wdata, store_prog_instr, addr_pointer, data_register_pair,
           eeprom_busy,
    output ctrl_rdata, core_stall, busy
  );
  modport core (
    output ctrl_wr, ctrl_wdata, store_prog_instr, addr_pointer, data_register_pair,
           eeprom_busy,
    input  ctrl_rdata, core_stall, busy
  );
endinterface : flash_selfprog_if

/* File: flash_page_selfprog.sv */
// Flash page self-programming sequencer: control register, page buffer, erase and write.
`timescale 1ns/1ps
module flash_page_selfprog #(
  parameter int unsigned WORD_W       = flash_selfprog_pkg::WORD_W,
  parameter int unsigned PAGE_W       = 9,
  parameter int unsigned ERASE_CYCLES = flash_selfprog_pkg::ERASE_CYCLES,
  parameter int unsigned WRITE_CYCLES = flash_selfprog_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  // Link to the core
  flash_selfprog_if.device             bus,
  // Flash array side
  output logic                         o_erase_pulse,
  output logic                         o_write_pulse,
  output logic [PAGE_W-1:0]            o_page_addr,
  output logic [WORD_W-1:0]            o_rd_index,
  output logic [15:0]                  o_rd_data,
  input  wire logic [WORD_W-1:0]       i_rd_index
);

  localparam int unsigned DEPTH = 1 << WORD_W;
  localparam int unsigned TW    = flash_selfprog_pkg::TIMER_W;

  // ==========================================================================
  // State and storage
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } seq_state_t;

  seq_state_t               state_reg;
  seq_state_t               state_next;
  logic [7:0]               ctrl_reg;
  logic [7:0]               ctrl_next;
  logic [2:0]               arm_reg;
  logic [TW-1:0]            timer_reg;
  logic [15:0]              buf_mem [DEPTH];
  logic [DEPTH-1:0]         valid_reg;
  logic [PAGE_W-1:0]        page_reg;
  logic                     loading_reg;
  logic [15:0]              rd_reg;
  logic [WORD_W-1:0]        rd_index_reg;

  // ==========================================================================
  // Command decode
  // ==========================================================================
  wire [5:0] low_code   = bus.ctrl_wdata[5:0];
  // Control writes are refused while an operation runs or the EEPROM is busy.
  wire       wr_ok      = bus.ctrl_wr & ~bus.eeprom_busy & (state_reg == ST_IDLE);
  wire       code_valid = (low_code == flash_selfprog_pkg::CMD_LOAD)
                        | (low_code == flash_selfprog_pkg::CMD_ERASE)
                        | (low_code == flash_selfprog_pkg::CMD_WRITE)
                        | (low_code == flash_selfprog_pkg::CMD_CLEAR);
  wire       armed      = ctrl_reg[flash_selfprog_pkg::BIT_ENABLE] & (state_reg == ST_IDLE);
  // A store is honoured only while armed; an unarmed store does nothing.
  wire       fire       = armed & bus.store_prog_instr & ~bus.eeprom_busy;
  wire [5:0] armed_code = ctrl_reg[5:0];
  wire       do_erase   = fire & (armed_code == flash_selfprog_pkg::CMD_ERASE);
  wire       do_write   = fire & (armed_code == flash_selfprog_pkg::CMD_WRITE);
  wire       do_load    = fire & (armed_code == flash_selfprog_pkg::CMD_LOAD);
  wire       do_clear   = wr_ok & (low_code == flash_selfprog_pkg::CMD_CLEAR);
  // Erase and write take the page only from the page-index field.
  wire [PAGE_W-1:0] ptr_page = bus.addr_pointer[WORD_W+1 +: PAGE_W];
  // Byte bit zero is ignored; word field selects the slot, any order.
  wire [WORD_W-1:0] ptr_word = bus.addr_pointer[WORD_W:1];
  wire       timer_done = (timer_reg == '0);
  wire       op_done    = (state_reg != ST_IDLE) & timer_done;
  // The arm counter restarts on each accepted control write, so a store that comes
  // later than four cycles finds the enable bit already cleared.
  wire       arm_expire = armed & (arm_reg == 3'(flash_selfprog_pkg::ARM_CYCLES - 1));
  wire       discard    = bus.eeprom_busy & loading_reg;
  wire       wipe       = do_clear | (op_done & (state_reg == ST_WRITE)) | discard;

  // ==========================================================================
  // Control register and sequencer
  // ==========================================================================
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    state_next = state_reg;
    if (wr_ok && code_valid && low_code != flash_selfprog_pkg::CMD_CLEAR)
      ctrl_next = {2'b00, low_code};
    else if (fire && !do_erase && !do_write)
      ctrl_next = flash_selfprog_pkg::CTRL_RESET;
    else if (arm_expire && !fire)
      ctrl_next = flash_selfprog_pkg::CTRL_RESET;
    else if (op_done)
      ctrl_next = flash_selfprog_pkg::CTRL_RESET;
    case (state_reg)
      ST_IDLE:
      begin
        if (do_erase)
          state_next = ST_ERASE;
        else if (do_write)
          state_next = ST_WRITE;
      end
      ST_ERASE, ST_WRITE:
      begin
        if (timer_done)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= ST_IDLE;
      ctrl_reg  <= flash_selfprog_pkg::CTRL_RESET;
      arm_reg   <= 3'h0;
      timer_reg <= '0;
      page_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
      arm_reg   <= (wr_ok && code_valid) ? 3'h0 : arm_reg + 3'h1;
      // Loaded with one less than the count, so busy lasts exactly the set cycles.
      // Cycle counts must not exceed two to the power TW or they are cut short.
      if (do_erase)
        timer_reg <= TW'(ERASE_CYCLES - 1);
      else if (do_write)
        timer_reg <= TW'(WRITE_CYCLES - 1);
      else if (!timer_done)
        timer_reg <= timer_reg - 1'b1;
      if (do_erase || do_write)
        page_reg <= ptr_page;
    end
  end

  // ==========================================================================
  // Temporary page buffer
  // ==========================================================================
  // The data pair is only sampled on a load; erase and write never read it.
  always_ff @(posedge i_clock)
  begin
    if (do_load && !valid_reg[ptr_word])
      buf_mem[ptr_word] <= bus.data_register_pair;
  end

  // Valid bits stand in for clearing the array: an invalid slot reads as erased.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      valid_reg   <= '0;
      loading_reg <= 1'b0;
      rd_reg      <= 16'hffff;
      rd_index_reg <= '0;
    end
    else
    begin
      if (wipe)
      begin
        valid_reg   <= '0;
        loading_reg <= 1'b0;
      end
      else if (do_load)
      begin
        valid_reg[ptr_word] <= 1'b1;
        loading_reg         <= 1'b1;
      end
      // The index is registered with the data so both name the same slot.
      rd_reg <= valid_reg[i_rd_index] ? buf_mem[i_rd_index] : 16'hffff;
      rd_index_reg <= i_rd_index;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign bus.busy       = (state_reg != ST_IDLE);
  assign bus.core_stall = (state_reg != ST_IDLE);
  assign bus.ctrl_rdata = ctrl_reg;
  assign o_erase_pulse  = do_erase;
  assign o_write_pulse  = do_write;
  assign o_page_addr    = page_reg;
  assign o_rd_index     = rd_index_reg;
  assign o_rd_data      = rd_reg;

endmodule : flash_page_selfprog

/* File: flash_selfprog_core.sv */
// Core-side end: turns user command requests into register write plus store instruction (register write only for clear).
`timescale 1ns/1ps
module flash_selfprog_core (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_reset_n,
  // User command side
  input  wire logic         i_req,
  input  wire logic [5:0]   i_code,
  input  wire logic [15:0]  i_addr,
  input  wire logic [15:0]  i_data,
  input  wire logic         i_eeprom_busy,
  output logic              o_ready,
  output logic              o_done,
  // Link to the sequencer
  flash_selfprog_if.core    bus
);

  typedef enum logic [3:0] {
    CS_IDLE  = 4'b0001,
    CS_CTRL  = 4'b0010,
    CS_STORE = 4'b0100,
    CS_WAIT  = 4'b1000
  } core_state_t;

  core_state_t  state_reg;
  logic [5:0]   code_reg;
  logic [15:0]  addr_reg;
  logic [15:0]  data_reg;
  logic         done_reg;

  // ==========================================================================
  // Sequence: control write, then store in the next cycle (no store for clear), well inside four.
  // ==========================================================================
  wire take = i_req & (state_reg == CS_IDLE) & ~i_eeprom_busy;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= CS_IDLE;
      code_reg  <= 6'h00;
      addr_reg  <= 16'h0000;
      data_reg  <= 16'h0000;
      done_reg  <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        CS_IDLE:
        begin
          if (take)
          begin
            code_reg  <= i_code;
            addr_reg  <= i_addr;
            data_reg  <= i_data;
            state_reg <= CS_CTRL;
          end
        end
        CS_CTRL:  state_reg <= (code_reg == flash_selfprog_pkg::CMD_CLEAR) ? CS_WAIT : CS_STORE;
        CS_STORE: state_reg <= CS_WAIT;
        CS_WAIT:
        begin
          if (!bus.core_stall)
          begin
            done_reg  <= 1'b1;
            state_reg <= CS_IDLE;
          end
        end
        default:  state_reg <= CS_IDLE;
      endcase
    end
  end

  assign bus.ctrl_wr            = (state_reg == CS_CTRL);
  assign bus.ctrl_wdata         = {2'b00, code_reg};
  assign bus.store_prog_instr   = (state_reg == CS_STORE);
  assign bus.addr_pointer       = addr_reg;
  assign bus.data_register_pair = data_reg;
  assign bus.eeprom_busy        = i_eeprom_busy;
  assign o_ready                = (state_reg == CS_IDLE) & ~i_eeprom_busy;
  assign o_done                 = done_reg;

endmodule : flash_selfprog_core

/* File: flash_page_selfprog_asserts.sv */
// Concurrent checks on the link between the core end and the flash sequencer.
`timescale 1ns/1ps
module flash_page_selfprog_asserts #(
  parameter int unsigned OP_CYCLES = 8
) (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  ctrl_rdata,
  input wire logic        store_prog_instr,
  input wire logic        eeprom_busy,
  input wire logic        core_stall,
  input wire logic        busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Counts the cycles of one erase or write so its length can be checked on the fall.
  logic [15:0] run_reg;
  wire         idle_take = store_prog_instr && !busy && !eeprom_busy;
  wire         bad_code  = !(ctrl_wdata[5:0] inside {6'h01, 6'h03, 6'h05, 6'h11});
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n) run_reg <= 16'h0000;
    else            run_reg <= busy ? run_reg + 16'h0001 : 16'h0000;
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  op_length_a: assert property ($fell(busy) |-> run_reg == OP_CYCLES[15:0])
    else $error("erase or write length differs from the set cycle count");
  erase_start_a: assert property (idle_take && ctrl_rdata[2:0] == 3'h3 |=> busy)
    else $error("armed erase did not start");
  write_start_a: assert property (idle_take && ctrl_rdata[2:0] == 3'h5 |=> busy)
    else $error("armed write did not start");
  load_done_a: assert property (idle_take && ctrl_rdata[5:0] == 6'h01 |=> !busy && !ctrl_rdata[0])
    else $error("word load stalled or left enable set");
  stall_match_a: assert property (core_stall == busy)
    else $error("core stall differs from busy");
  stall_cause_a: assert property ($rose(core_stall) |-> $past(store_prog_instr))
    else $error("core stall rose without a store instruction");
  enable_held_a: assert property (busy |-> ctrl_rdata[0])
    else $error("enable dropped during an operation");
  enable_expiry_a: assert property ((ctrl_rdata[0] && !busy && !store_prog_instr) [*5] |-> 1'b0)
    else $error("enable stayed set beyond four cycles");
  eeprom_block_a: assert property (eeprom_busy && !busy |=> !busy)
    else $error("operation started during an eeprom write");
  bad_code_a: assert property (ctrl_wr && bad_code && ctrl_rdata == 8'h00 |=> ctrl_rdata == 8'h00)
    else $error("undefined command changed the control register");
endmodule : flash_page_selfprog_asserts

/* File: flash_page_selfprog_test.sv */
// Testbench joining both ends of the self-programming link.
`timescale 1ns/1ps
module flash_page_selfprog_test;
  logic        i_clock = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_req = 1'b0;
  logic [5:0]  i_code = 6'h00;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_data = 16'h0000;
  logic        i_eeprom_busy = 1'b0;
  logic [5:0]  i_rd_index = 6'h00;
  logic        o_ready;
  logic        o_done;
  logic [8:0]  o_page_addr;
  logic [15:0] o_rd_data;
  logic        o_erase_pulse;
  logic        o_write_pulse;
  logic [5:0]  o_rd_index;
  int          erase_count = 0;
  int          write_count = 0;
  int          fail_count = 0;
  int          compares = 0;
  logic [5:0]  bad_codes [4] = '{6'h00, 6'h07, 6'h21, 6'h3f};

  flash_selfprog_if link ();
  flash_selfprog_core u_flash_selfprog_core (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_req(i_req), .i_code(i_code), .i_addr(i_addr), .i_data(i_data),
    .i_eeprom_busy(i_eeprom_busy), .o_ready(o_ready), .o_done(o_done), .bus(link));
  flash_page_selfprog #(.ERASE_CYCLES(8), .WRITE_CYCLES(8)) u_flash_page_selfprog (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .bus(link), .o_erase_pulse(o_erase_pulse),
    .o_write_pulse(o_write_pulse), .o_page_addr(o_page_addr), .o_rd_index(o_rd_index),
    .o_rd_data(o_rd_data), .i_rd_index(i_rd_index));
  flash_page_selfprog_asserts #(.OP_CYCLES(8)) u_flash_page_selfprog_asserts (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
    .store_prog_instr(link.store_prog_instr), .eeprom_busy(link.eeprom_busy),
    .core_stall(link.core_stall), .busy(link.busy));

  initial
  begin
    forever #2.5 i_clock = ~i_clock;
  end

  // Each accepted erase or write shows a one-cycle pulse; count them at the falling edge.
  always @(negedge i_clock)
  begin
    if (o_erase_pulse === 1'b1) erase_count++;
    if (o_write_pulse === 1'b1) write_count++;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Byte pointer: page in the top bits, word in page above the ignored low bit.
  function automatic logic [15:0] za(input logic [8:0] p, input logic [5:0] w);
    return {p, w, 1'b0};
  endfunction : za

  task automatic cmd(input logic [5:0] c, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(negedge i_clock);
    {i_req, i_code, i_addr, i_data} = {1'b1, c, a, d};
    for (n = 0; n < 100 && o_ready !== 1'b1; n++) @(negedge i_clock);
    @(negedge i_clock);
    i_req = 1'b0;
    for (n = 0; n < 100 && o_done !== 1'b1; n++) @(negedge i_clock);
    if (n == 100) chk("done", 16'h0001, 16'h0000);
  endtask : cmd

  task automatic rd(input logic [5:0] idx, input logic [15:0] e);
    @(negedge i_clock);
    i_rd_index = idx;
    @(negedge i_clock);
    chk("slot", e, o_rd_data);
    chk("slot index", {10'h000, idx}, {10'h000, o_rd_index});
  endtask : rd

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (12) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd(6'h00, 16'hffff);
    cmd(6'h01, za(9'h003, 6'h05), 16'h1234);
    cmd(6'h01, za(9'h003, 6'h02), 16'habcd);
    cmd(6'h01, za(9'h003, 6'h05), 16'h5555);
    rd(6'h05, 16'h1234);
    rd(6'h02, 16'habcd);
    foreach (bad_codes[i]) cmd(bad_codes[i], za(9'h003, 6'h07), 16'h0bad);
    rd(6'h07, 16'hffff);
    cmd(6'h03, za(9'h003, 6'h09) | 16'h0001, 16'hdead);
    chk("page", 16'h0003, {7'h00, o_page_addr});
    chk("erase count", 16'h0001, 16'(erase_count));
    rd(6'h05, 16'h1234);
    cmd(6'h05, za(9'h003, 6'h00), 16'h0000);
    chk("page", 16'h0003, {7'h00, o_page_addr});
    chk("write count", 16'h0001, 16'(write_count));
    rd(6'h05, 16'hffff);
    cmd(6'h01, za(9'h001, 6'h3f), 16'h0f0f);
    rd(6'h3f, 16'h0f0f);
    cmd(6'h11, za(9'h001, 6'h00), 16'h0000);
    rd(6'h3f, 16'hffff);
    cmd(6'h01, za(9'h001, 6'h10), 16'h7777);
    @(negedge i_clock);
    i_eeprom_busy = 1'b1;
    repeat (2) @(negedge i_clock);
    i_eeprom_busy = 1'b0;
    rd(6'h10, 16'hffff);
    // The EEPROM turns busy after the core has taken the erase, so the sequencer must refuse it.
    fork
      cmd(6'h03, za(9'h005, 6'h00), 16'h0000);
      begin
        repeat (2) @(negedge i_clock);
        i_eeprom_busy = 1'b1;
      end
    join
    i_eeprom_busy = 1'b0;
    chk("page", 16'h0003, {7'h00, o_page_addr});
    chk("erase count", 16'h0001, 16'(erase_count));
    end_of_test();
  end

  initial
  begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule : flash_page_selfprog_test
